// ### hw/dhe_pkg.sv
// Constants and carrier types for the DMA handshake and end-of-transfer block.
// Assumes one device clock; pins are synchronised inside the top module.
// What this block does
// - Acknowledge-strobe mode bit selects strobe mode.
// - Strobe mode uses acknowledge; read/write strobes ignored.
// - Request out; acknowledge confirms; end input terminates.
// - Bulk ends: end input, count, short, disable.
// - OUT end input stops, discards current buffer.
// - IN end stops, validates packet for sending.
// - Count termination only with counter enable.
// - Sixteen-bit byte count register held.
// - Internal counter loads when DMA enabled.
// - Count reached raises end, halts DMA.
// - Short packet stops after its bytes move.
// - IN short mode ends at zero midbuffer.
// - Disable stops DMA without any interrupt.
// - Isochronous also ends on end-of-packet.
// - Acknowledge selects configured endpoint index.
// - Direction bit: zero OUT read, one IN write.
// - Single drops request per unit; burst per cycle.
package dhe_pkg;

    localparam int CNT_W      = 16;
    localparam int EP_IDX_W   = 4;
    localparam int BURST_W    = 5;
    localparam logic [CNT_W-1:0]   CNT_RST   = 16'h0000;
    localparam logic [BURST_W-1:0] BURST_MAX = 5'h10;
    localparam logic [BURST_W-1:0] BURST_ONE = 5'h01;

    // Configuration from the register side of the device.
    typedef struct packed {
        logic                dma_enable_bit;
        logic                ack_strobe_mode_sel;
        logic                count_term_en;
        logic                short_pkt_term_en;
        logic                burst_mode;
        logic [BURST_W-1:0]  burst_len;
        logic [EP_IDX_W-1:0] dma_ep_index;
        logic [CNT_W-1:0]    dma_count;
    } dhe_cfg_t;

    // State of the endpoint selected by dma_ep_index.
    typedef struct packed {
        logic ep_direction_bit;
        logic ep_iso;
        logic buf_ready;
        logic short_pkt_last;
        logic usb_eop;
    } dhe_ep_t;

    // Commands and status towards the endpoint buffer manager.
    typedef struct packed {
        logic                xfer_stb;
        logic                xfer_write;
        logic [EP_IDX_W-1:0] xfer_ep;
        logic                discard_buf;
        logic                validate_buf;
        logic                dma_done;
        logic                dma_active;
    } dhe_buf_cmd_t;

    typedef enum logic [1:0] {
        DHE_END_EXT,
        DHE_END_CNT,
        DHE_END_PKT,
        DHE_END_DIS
    } dhe_end_t;

endpackage : dhe_pkg

// ### hw/dhe_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to clk.
module dhe_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // dhe_sync

// ### hw/dhe_dma_ctrl.sv
// DMA request, acknowledge strobe and end-of-transfer control.
// Assumes the partner drives active-high acknowledge, strobes and end pins.
module dhe_dma_ctrl (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // Configuration and selected endpoint state
    input  wire dhe_pkg::dhe_cfg_t     cfg,
    input  wire dhe_pkg::dhe_ep_t      ep,
    // Link pins
    input  wire logic                  dma_ack_in,
    input  wire logic                  xfer_end_in,
    input  wire logic                  rd_strobe_in,
    input  wire logic                  wr_strobe_in,
    output logic                       dma_req_out,
    // Buffer manager side
    output dhe_pkg::dhe_buf_cmd_t      buf_cmd,
    output logic [dhe_pkg::CNT_W-1:0]  count_left,
    output logic [1:0]                 end_cause
);
    import dhe_pkg::*;

    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [3:0] pin_s;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    dhe_sync #(.W(4)) u_sync (
        .clk   (clk),
        .rst_n (rst_n_q),
        .d     ({dma_ack_in, xfer_end_in, rd_strobe_in, wr_strobe_in}),
        .q     (pin_s)
    );

    wire ack_s = pin_s[3];
    wire end_s = pin_s[2];
    wire rd_s  = pin_s[1];
    wire wr_s  = pin_s[0];

    // ----------------------------------------
    // Strobe selection and edge detect
    // ----------------------------------------
    logic strobe_q;
    logic end_q;
    logic en_q;

    // Strobe mode takes acknowledge itself; otherwise a read or write strobe
    // qualified by acknowledge. Direction picks which strobe counts.
    wire dir_in      = ep.ep_direction_bit;
    wire legacy_stb  = ack_s & (dir_in ? wr_s : rd_s);
    wire strobe_lvl  = cfg.ack_strobe_mode_sel ? ack_s : legacy_stb;
    wire strobe_fall = strobe_q & ~strobe_lvl;
    wire end_rise    = end_s & ~end_q;
    wire en_rise     = cfg.dma_enable_bit & ~en_q;
    wire en_fall     = ~cfg.dma_enable_bit & en_q;

    // ----------------------------------------
    // Transfer state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE
    } dhe_st_t;

    dhe_st_t             st_q, st_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic [BURST_W-1:0]  burst_q, burst_d;
    logic                req_q, req_d;
    dhe_buf_cmd_t        cmd_q, cmd_d;
    logic [1:0]          cause_q, cause_d;

    wire unit_done  = (st_q == ST_RUN) & strobe_fall;
    wire cnt_last   = (cnt_q == 16'h0001);
    wire cnt_hit    = cfg.count_term_en & unit_done & cnt_last;
    wire short_hit  = cfg.short_pkt_term_en & ~ep.ep_iso & unit_done
                    & (dir_in ? cnt_last : ep.short_pkt_last);
    wire eop_hit    = ep.ep_iso & ep.usb_eop & (st_q == ST_RUN);
    wire ext_hit    = end_rise & (st_q == ST_RUN);
    wire burst_end  = ~cfg.burst_mode | (burst_q == BURST_ONE);
    // A programmed length of zero stands for a burst of BURST_MAX (16) units.
    wire logic [BURST_W-1:0] burst_len1 = (cfg.burst_len == '0) ? BURST_MAX : cfg.burst_len;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        burst_d = burst_q;
        req_d   = req_q;
        cause_d = cause_q;
        cmd_d   = '0;
        cmd_d.xfer_ep    = cfg.dma_ep_index;
        cmd_d.xfer_write = dir_in;
        cmd_d.dma_active = (st_q == ST_RUN);
        case (st_q)
            ST_IDLE: begin
                req_d = 1'b0;
                if (en_rise) begin
                    cnt_d   = cfg.dma_count;
                    burst_d = burst_len1;
                    st_d    = ST_RUN;
                end
            end
            ST_RUN: begin
                if (unit_done) begin
                    cmd_d.xfer_stb = 1'b1;
                    cnt_d          = cnt_q - 16'h0001;
                    burst_d        = burst_end ? burst_len1 : burst_q - BURST_ONE;
                end
                // Drop request after each unit in single mode, or at the end of a burst.
                if (unit_done && burst_end) begin
                    req_d = 1'b0;
                end else if (!ack_s) begin
                    req_d = cfg.dma_enable_bit & ep.buf_ready;
                end
                if (en_fall) begin
                    st_d    = ST_IDLE;
                    req_d   = 1'b0;
                    cause_d = DHE_END_DIS;
                end else if (ext_hit) begin
                    st_d               = ST_DONE;
                    req_d              = 1'b0;
                    cause_d            = DHE_END_EXT;
                    cmd_d.discard_buf  = ~dir_in;
                    cmd_d.validate_buf = dir_in;
                    cmd_d.dma_done     = 1'b1;
                end else if (cnt_hit || short_hit || eop_hit) begin
                    st_d               = ST_DONE;
                    req_d              = 1'b0;
                    cause_d            = cnt_hit ? DHE_END_CNT : DHE_END_PKT;
                    cmd_d.validate_buf = dir_in;
                    cmd_d.dma_done     = 1'b1;
                end
            end
            ST_DONE: begin
                req_d = 1'b0;
                if (!cfg.dma_enable_bit) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d  = ST_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q     <= ST_IDLE;
            cnt_q    <= CNT_RST;
            burst_q  <= BURST_ONE;
            req_q    <= 1'b0;
            cmd_q    <= '0;
            cause_q  <= DHE_END_EXT;
            strobe_q <= 1'b0;
            end_q    <= 1'b0;
            en_q     <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            burst_q  <= burst_d;
            req_q    <= req_d;
            cmd_q    <= cmd_d;
            cause_q  <= cause_d;
            strobe_q <= strobe_lvl;
            end_q    <= end_s;
            en_q     <= cfg.dma_enable_bit;
        end
    end

    assign dma_req_out = req_q;
    assign buf_cmd     = cmd_q;
    assign count_left  = cnt_q;
    assign end_cause   = cause_q;
endmodule // dhe_dma_ctrl

// ### verif/dhe_dma_ctrl_asserts.sv
// Port checks for the DMA handshake block.
// Assumes a bind onto dhe_dma_ctrl with one clock.
module dhe_dma_ctrl_asserts
    import dhe_pkg::*;
(
    // Clock and reset
    input wire logic         clk,
    input wire logic         arst_n,
    // Watched ports
    input wire dhe_cfg_t     cfg,
    input wire dhe_ep_t      ep,
    input wire logic         dma_req_out,
    input wire dhe_buf_cmd_t buf_cmd,
    input wire logic [15:0]  count_left,
    input wire logic [1:0]   end_cause
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    req_needs_en_a: assert property (!cfg.dma_enable_bit [*3] |-> !dma_req_out) else $error("req off");
    count_step_a: assert property (buf_cmd.xfer_stb && $past(count_left) != CNT_RST
        |-> count_left == $past(count_left) - 16'h0001) else $error("count step");
    count_end_a: assert property (buf_cmd.dma_done && end_cause == DHE_END_CNT
        |-> cfg.count_term_en && count_left == CNT_RST && buf_cmd.xfer_stb) else $error("count end");
    dis_quiet_a: assert property (buf_cmd.dma_done |-> end_cause != DHE_END_DIS) else $error("disable done");
    dir_follow_a: assert property (buf_cmd.xfer_stb |-> buf_cmd.xfer_write == ep.ep_direction_bit)
        else $error("direction");
    ep_select_a: assert property (buf_cmd.xfer_stb |-> buf_cmd.xfer_ep == cfg.dma_ep_index)
        else $error("endpoint");
    discard_out_a: assert property (buf_cmd.discard_buf |-> !ep.ep_direction_bit && end_cause == DHE_END_EXT)
        else $error("discard");
    validate_in_a: assert property (buf_cmd.validate_buf |-> ep.ep_direction_bit) else $error("validate");
    single_drop_a: assert property (buf_cmd.xfer_stb && !cfg.burst_mode |-> !dma_req_out)
        else $error("single drop");
endmodule // dhe_dma_ctrl_asserts

// ### verif/dhe_ctrl_model.sv
// Behavioural DMA controller pulsing acknowledge on request.
// Assumes the bench owns the end pin and the stop level.
module dhe_ctrl_model (
    // Clock
    input wire logic       clk,
    // Handshake
    input wire logic       dma_req_out,
    input wire logic       stop,
    input wire logic [1:0] gap,
    output logic           dma_ack_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        dma_ack_in = 1'b0;
        forever begin
            @(negedge clk);
            if (dma_req_out && !stop) begin
                repeat (gap) @(negedge clk);
                dma_ack_in = 1'b1;
                repeat (3) @(negedge clk);
                dma_ack_in = 1'b0;
                repeat (8) @(negedge clk);
            end
        end
    end
endmodule // dhe_ctrl_model

// ### verif/dhe_dma_ctrl_tb.sv
// Self-checking bench for dhe_dma_ctrl.
// Assumes the controller model answers every request while stop is low.
module dhe_dma_ctrl_tb;
    import dhe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic mode, dir, iso, cen, sp, spl;
        logic [1:0] kind;
        logic [3:0] after;
        logic [1:0] gap;
        logic [15:0] count;
        logic [1:0] cause;
        logic [15:0] left;
    } dhe_row_t;
    // Strobe-mode rows keep rd and wr low, the legacy row raises them.
    dhe_row_t rows [7] = '{'{1,0,0,1,0,0,0,0,0,16'h0003,1,16'h0000}, '{1,1,0,1,0,0,0,0,2,16'h0002,1,16'h0000},
        '{1,0,0,0,0,0,1,2,1,16'h0009,0,16'h0007}, '{1,1,0,1,0,0,1,1,0,16'h0009,0,16'h0008},
        '{1,0,0,0,1,1,0,0,0,16'h0009,2,16'h0008}, '{1,0,1,0,0,0,2,1,3,16'h0009,2,16'h0008},
        '{0,0,0,1,0,0,0,0,0,16'h0002,1,16'h0000}};
    logic clk, arst_n, rd, wr, xfer_end_in, hold, ack, dma_req_out, dn;
    logic [1:0] gap, end_cause;
    logic [15:0] count_left;
    dhe_cfg_t cfg;
    dhe_ep_t ep;
    dhe_buf_cmd_t cmd;
    int fail_count, total_checks;
    dhe_dma_ctrl dut (.clk(clk), .arst_n(arst_n), .cfg(cfg), .ep(ep), .dma_ack_in(ack), .xfer_end_in(xfer_end_in),
        .rd_strobe_in(rd), .wr_strobe_in(wr), .dma_req_out(dma_req_out), .buf_cmd(cmd), .count_left(count_left),
        .end_cause(end_cause));
    dhe_ctrl_model pm (.clk(clk), .dma_req_out(dma_req_out), .stop(hold), .gap(gap), .dma_ack_in(ack));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run_row(input dhe_row_t r);
        int n;
        logic vs, ds;
        n = 0;
        vs = 1'b0;
        ds = 1'b0;
        dn = 1'b0;
        cfg = '{1'b1, r.mode, r.cen, r.sp, 1'b0, 5'h00, 4'h5, r.count};
        ep = '{r.dir, r.iso, 1'b1, r.spl, 1'b0};
        rd = !r.mode;
        wr = !r.mode;
        gap = r.gap;
        for (int i = 0; i < 500 && !dn; i++) begin
            @(negedge clk);
            n += cmd.xfer_stb;
            vs |= cmd.validate_buf;
            ds |= cmd.discard_buf;
            dn |= cmd.dma_done;
            ep.usb_eop = r.kind == 2'h2 && n == r.after && !hold;
            if (r.kind != 2'h0 && n == r.after) hold = 1'b1;
            xfer_end_in = hold && r.kind == 2'h1;
        end
        if (dn !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        check("cause", end_cause, r.cause);
        check("left", count_left, r.left);
        check("validate", vs, r.dir);
        check("discard", ds, r.kind == 2'h1 && !r.dir);
        cfg.dma_enable_bit = 1'b0;
        hold = 1'b0;
        xfer_end_in = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {arst_n, rd, wr, xfer_end_in, hold, dn, gap, cfg, ep} = '0;
        repeat (4) @(negedge clk);
        check("req_rst", dma_req_out, 1'b0);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        foreach (rows[k]) run_row(rows[k]);
        cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 4'h5, 16'h0009};
        ep = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 200 && cmd.xfer_stb !== 1'b1; i++) @(negedge clk);
        check("dis_stb", cmd.xfer_stb, 1'b1);
        check("active_on", cmd.dma_active, 1'b1);
        cfg.dma_enable_bit = 1'b0;
        dn = 1'b0;
        repeat (12) begin
            @(negedge clk);
            dn |= cmd.dma_done;
        end
        check("dis_done", dn, 1'b0);
        check("dis_cause", end_cause, DHE_END_DIS);
        check("dis_req", dma_req_out, 1'b0);
        check("active_off", cmd.dma_active, 1'b0);
        cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 5'h02, 4'h5, 16'h0004};
        for (int i = 0; i < 200 && cmd.xfer_stb !== 1'b1; i++) @(negedge clk);
        check("burst_hold", dma_req_out, 1'b1);
        @(negedge clk);
        for (int i = 0; i < 200 && cmd.xfer_stb !== 1'b1; i++) @(negedge clk);
        check("burst_drop", dma_req_out, 1'b0);
        check("burst_left", count_left, 16'h0002);
        cfg.dma_enable_bit = 1'b0;
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule // dhe_dma_ctrl_tb
bind dhe_dma_ctrl dhe_dma_ctrl_asserts chk (.clk(clk), .arst_n(arst_n), .cfg(cfg), .ep(ep), .dma_req_out(dma_req_out),
    .buf_cmd(buf_cmd), .count_left(count_left), .end_cause(end_cause));
